// >>> src/static_cs_config_timing.sv
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module static_cs_config_timing (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic power_on_reset_n_in,
    input wire logic [3:0] bank_polarity_strap_in,
    input wire logic [1:0] bank1_width_strap_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic ready_out,
    input wire static_cs_pkg::mem_req_t req_in,
    output logic req_ready_out,
    output logic [3:0] cs_out,
    output logic we_n_out,
    output logic oe_n_out,
    output logic [31:0] mem_addr_out,
    output logic [1:0] cur_width_out,
    output logic busy_out
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_BEAT = 4'h4,
        ST_DONE = 4'h8
    } acc_state_t;

    static_cs_pkg::bank_cfg_t cfg_q [static_cs_pkg::NUM_BANKS];
    acc_state_t state_q;
    static_cs_pkg::mem_req_t cur_q;
    logic [2:0] beats_left_q;
    logic started_q;
    logic timer_start;
    logic timer_done;
    logic [3:0] timer_delay;
    logic [3:0] timer_off;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic pend_q;
    logic pend_d;
    logic [1:0] idx;
    logic sel_cfg;
    logic sel_wen;
    logic sel_oen;
    logic sel_dly;
    logic reg_acc;
    logic [3:0] wr_bank;
    acc_state_t state_d;
    static_cs_pkg::mem_req_t cur_d;
    logic [2:0] beats_left_d;
    logic [2:0] first_beats;
    logic page_read;
    logic strobe_on;
    logic [1:0] width_q;

    function automatic logic [3:0] bank_onehot(input logic [1:0] b);
        bank_onehot = 4'h1 << b;
    endfunction : bank_onehot

    // register group hit on the upper address nibble
    function automatic logic group_hit(input logic [7:0] a, input logic [7:0] base);
        group_hit = (a[7:4] == base[7:4]);
    endfunction : group_hit

    // page bursts are capped at the page length
    function automatic logic [2:0] clip_beats(input logic [2:0] n);
        if (n > static_cs_pkg::PAGE_LENGTH) begin
            clip_beats = static_cs_pkg::PAGE_LENGTH;
        end else begin
            clip_beats = n;
        end
    endfunction : clip_beats

    // states in which the bank's chip select is driven
    function automatic logic holds_cs(input acc_state_t s);
        holds_cs = (s == ST_WAIT) || (s == ST_BEAT);
    endfunction : holds_cs

    // reserved config bits always read back as zero
    function automatic logic [31:0] cfg_word(input static_cs_pkg::bank_cfg_t c);
        cfg_word = 32'h00000000;
        cfg_word[static_cs_pkg::POL_BIT] = c.pol;
        cfg_word[static_cs_pkg::PAGE_BIT] = c.page;
        cfg_word[static_cs_pkg::WIDTH_LSB +: 2] = c.width;
    endfunction : cfg_word

    function automatic logic [31:0] dly_word(input logic [3:0] d);
        dly_word = {28'h0000000, d};
    endfunction : dly_word

    assign idx = addr_in[3:2];
    assign sel_cfg = group_hit(addr_in, static_cs_pkg::CFG_BASE);
    assign sel_wen = group_hit(addr_in, static_cs_pkg::WEN_BASE);
    assign sel_oen = group_hit(addr_in, static_cs_pkg::OEN_BASE);
    assign sel_dly = sel_wen || sel_oen;
    assign reg_acc = wr_in || rd_in;
    assign wr_bank = wr_in ? bank_onehot(idx) : 4'h0;

    genvar g;
    generate
        for (g = 0; g < static_cs_pkg::NUM_BANKS; g++) begin : g_bank
            logic strap_pend_q;
            // strap levels cannot be loaded under async reset, so catch after release
            always_ff @(posedge clk_in or negedge power_on_reset_n_in) begin
                if (!power_on_reset_n_in) begin
                    strap_pend_q <= 1'b1;
                end else begin
                    strap_pend_q <= 1'b0;
                end
            end
            always_ff @(posedge clk_in or negedge power_on_reset_n_in) begin
                if (!power_on_reset_n_in) begin
                    cfg_q[g].pol <= 1'b0;
                    cfg_q[g].page <= static_cs_pkg::PAGE_RESET;
                    cfg_q[g].width <= static_cs_pkg::WIDTH_RESET;
                    cfg_q[g].we_dly <= static_cs_pkg::DELAY_RESET;
                    cfg_q[g].oe_dly <= static_cs_pkg::DELAY_RESET;
                end else if (strap_pend_q) begin
                    cfg_q[g].pol <= bank_polarity_strap_in[g];
                    cfg_q[g].width <= (g == 1) ? bank1_width_strap_in : static_cs_pkg::WIDTH_RESET;
                end else if (wr_bank[g]) begin
                    if (sel_cfg) begin
                        cfg_q[g].pol <= wdata_in[static_cs_pkg::POL_BIT];
                        cfg_q[g].page <= wdata_in[static_cs_pkg::PAGE_BIT];
                        cfg_q[g].width <= wdata_in[static_cs_pkg::WIDTH_LSB +: 2];
                    end
                    if (sel_wen) begin
                        cfg_q[g].we_dly <= wdata_in[3:0];
                    end
                    if (sel_oen) begin
                        cfg_q[g].oe_dly <= wdata_in[3:0];
                    end
                end
            end
        end
    endgenerate

    // one wait state on delay registers
    // every delay access flags its own wait state, back to back too
    assign pend_d = reg_acc && sel_dly;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end

    assign ready_out = !pend_q;

    // unmapped groups read as zero
    always_comb begin
        rdata_d = 32'h00000000;
        if (sel_cfg) begin
            rdata_d = cfg_word(cfg_q[idx]);
        end else if (sel_wen) begin
            rdata_d = dly_word(cfg_q[idx].we_dly);
        end else if (sel_oen) begin
            rdata_d = dly_word(cfg_q[idx].oe_dly);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 32'h00000000;
        end else if (rd_in) begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;

    assign page_read = cfg_q[req_in.bank].page && !req_in.write;
    assign first_beats = page_read ? clip_beats(req_in.beats) : 3'h1;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (req_in.valid) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (timer_done) begin
                    state_d = ST_BEAT;
                end
            end
            ST_BEAT: begin
                if (beats_left_q <= 3'h1) begin
                    state_d = ST_DONE;
                end else begin
                    state_d = ST_WAIT;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // each further page beat is an address change
    always_comb begin
        cur_d = cur_q;
        beats_left_d = beats_left_q;
        case (state_q)
            ST_IDLE: begin
                if (req_in.valid) begin
                    cur_d = req_in;
                    beats_left_d = first_beats;
                end
            end
            ST_BEAT: begin
                if (beats_left_q > 3'h1) begin
                    cur_d.addr = cur_q.addr + 32'h00000004;
                    beats_left_d = beats_left_q - 3'h1;
                end
            end
            default: begin
                beats_left_d = beats_left_q;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur_q <= '0;
        end else begin
            cur_q <= cur_d;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            beats_left_q <= 3'h0;
        end else begin
            beats_left_q <= beats_left_d;
        end
    end

    // width held with the access, so a later config write cannot tear it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            width_q <= static_cs_pkg::WIDTH_RESET;
        end else if (state_q == ST_IDLE && req_in.valid) begin
            width_q <= cfg_q[req_in.bank].width;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            started_q <= 1'b0;
        end else begin
            started_q <= (state_q == ST_WAIT);
        end
    end

    // restart on chip select or address change
    assign timer_start = (state_q == ST_WAIT) && !started_q;
    assign timer_delay = cur_q.write ? cfg_q[cur_q.bank].we_dly : cfg_q[cur_q.bank].oe_dly;
    assign timer_off = cur_q.write ? 4'h1 : 4'h0;

    static_strobe_timer u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .start_in(timer_start),
        .delay_in(timer_delay),
        .offset_in(timer_off),
        .done_out(timer_done)
    );

    logic [3:0] cs_act;
    assign cs_act = holds_cs(state_q) ? bank_onehot(cur_q.bank) : 4'h0;
    generate
        for (g = 0; g < static_cs_pkg::NUM_BANKS; g++) begin : g_cs
            assign cs_out[g] = cfg_q[g].pol ? cs_act[g] : !cs_act[g];
        end
    endgenerate


    // strobe stands from the end of the delay through the beat
    always_comb begin
        strobe_on = 1'b0;
        case (state_q)
            ST_WAIT: strobe_on = timer_done;
            ST_BEAT: strobe_on = 1'b1;
            default: strobe_on = 1'b0;
        endcase
    end

    assign we_n_out = !(cur_q.write && strobe_on);
    assign oe_n_out = !(!cur_q.write && strobe_on);
    assign mem_addr_out = cur_q.addr;
    assign cur_width_out = width_q;
    assign busy_out = (state_q != ST_IDLE);
    assign req_ready_out = (state_q == ST_IDLE);
endmodule : static_cs_config_timing

// >>> src/static_cs_pkg.sv
// Function
// - chip select is active low when polarity bit is 0, active high when 1.
// - polarity bit loads from its strap on power-on reset; bus reset keeps it.
// - page bit clear gives normal accesses; set allows read bursts of up to four, writes stay single.
// - width field 00 is 8-bit, 01 16-bit, 10 32-bit; banks 0,2,3 reset 8-bit.
// - bank 1 width loads from its two-bit strap on power-on reset.
// - strap-loaded fields read the strap until written, then the last write.
// - only asynchronous normal or page accesses are generated, never sync burst.
// - write enable follows chip select by the write delay plus one cycle.
// - output enable follows chip select or address change by the output delay.
// - output delay of zero asserts output enable with no added delay.
// - delay register accesses complete with one inserted wait state.
package static_cs_pkg;
    localparam int NUM_BANKS = 4;
    localparam logic [7:0] CFG_BASE = 8'h00;
    localparam logic [7:0] WEN_BASE = 8'h10;
    localparam logic [7:0] OEN_BASE = 8'h20;
    localparam int POL_BIT = 6;
    localparam int PAGE_BIT = 3;
    localparam int WIDTH_LSB = 0;
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    localparam logic [1:0] WIDTH_RESET = 2'h0;
    localparam logic PAGE_RESET = 1'h0;
    localparam logic [3:0] DELAY_RESET = 4'h0;
    localparam logic [2:0] PAGE_LENGTH = 3'h4;
    localparam logic [31:0] BEAT_TIME_NS = 32'h4;

    typedef struct packed {
        logic pol;
        logic page;
        logic [1:0] width;
        logic [3:0] we_dly;
        logic [3:0] oe_dly;
    } bank_cfg_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] bank;
        logic [2:0] beats;
        logic [31:0] addr;
    } mem_req_t;
endpackage : static_cs_pkg

// >>> src/static_strobe_timer.sv
`timescale 1ns/10ps
module static_strobe_timer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [3:0] delay_in,
    input wire logic [3:0] offset_in,
    output logic done_out
);
    logic [4:0] cnt_q;
    logic run_q;
    logic [4:0] target;
    assign target = {1'b0, delay_in} + {1'b0, offset_in};
    logic [5:0] elapsed;
    assign elapsed = {1'b0, cnt_q} + 6'h01;
    // start cycle counts as the first cycle of the delay, and a stale count is ignored then
    assign done_out = start_in ? (target == 5'h00) : (run_q && (elapsed >= {1'b0, target}));
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= 5'h00;
            run_q <= 1'b0;
        end else if (start_in) begin
            cnt_q <= 5'h00;
            run_q <= 1'b1;
        end else if (run_q && cnt_q != 5'h1F) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
endmodule : static_strobe_timer

// >>> tb/static_cs_config_timing_sva.sv
`timescale 1ns/10ps
module static_cs_sva (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic power_on_reset_n_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic ready_out,
    input wire static_cs_pkg::mem_req_t req_in,
    input wire logic req_ready_out,
    input wire logic we_n_out,
    input wire logic oe_n_out,
    input wire logic busy_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in || !power_on_reset_n_in);
    sequence s_dly_acc;
        (wr_in || rd_in) && addr_in >= 8'h10 && addr_in < 8'h30;
    endsequence
    sequence s_take;
        req_in.valid && req_ready_out;
    endsequence
    property p_wait_state; s_dly_acc |=> !ready_out; endproperty
    a_wait_state: assert property (p_wait_state) else $error("no wait state");
    property p_no_wait; (wr_in || rd_in) && addr_in < 8'h10 |=> ready_out; endproperty
    a_no_wait: assert property (p_no_wait) else $error("config access stalled");
    property p_unmapped; rd_in && addr_in >= 8'h30 |=> rdata_out == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_take; s_take |=> busy_out; endproperty
    a_take: assert property (p_take) else $error("request not started");
    property p_strobe; s_take |-> ##[1:20] (!we_n_out || !oe_n_out); endproperty
    a_strobe: assert property (p_strobe) else $error("strobe late");
    property p_idle; !busy_out |-> we_n_out && oe_n_out; endproperty
    a_idle: assert property (p_idle) else $error("strobe while idle");
    property p_excl; !(!we_n_out && !oe_n_out); endproperty
    a_excl: assert property (p_excl) else $error("read and write strobes together");
    property p_busy; busy_out |-> !req_ready_out; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
endmodule : static_cs_sva

bind static_cs_config_timing static_cs_sva u_sva (.clk_in, .rst_n_in, .power_on_reset_n_in, .addr_in,
    .wr_in, .rd_in, .rdata_out, .ready_out, .req_in, .req_ready_out, .we_n_out, .oe_n_out, .busy_out);

// >>> tb/static_mem_model.sv
`timescale 1ns/10ps
module static_mem_model (
    input wire logic clk_in,
    input wire logic [3:0] cs_in,
    input wire logic [3:0] pol_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    output int oe_lat_out,
    output int we_lat_out
);
    int cnt = 0;
    always @(posedge clk_in) begin
        if (!(|(~(cs_in ^ pol_in)))) begin
            cnt = 0;
        end else begin
            if (cnt == 0) begin
                oe_lat_out = -1;
                we_lat_out = -1;
            end
            if (!oe_n_in && oe_lat_out < 0) oe_lat_out = cnt;
            if (!we_n_in && we_lat_out < 0) we_lat_out = cnt;
            cnt++;
        end
    end
endmodule : static_mem_model

// >>> tb/tb_static_cs_config_timing.sv
`timescale 1ns/10ps
module tb_static_cs_config_timing;
    logic clk_in = 0, rst_n_in = 0, power_on_reset_n_in = 0, wr_in = 0, rd_in = 0;
    logic [3:0] bank_polarity_strap_in, cs_out, pv;
    logic [1:0] bank1_width_strap_in, cur_width_out;
    logic [7:0] addr_in = 0;
    logic [31:0] wdata_in = 0, rdata_out, mem_addr_out;
    logic ready_out, req_ready_out, we_n_out, oe_n_out, busy_out;
    static_cs_pkg::mem_req_t req_in = '0;
    int seed = 86, n_errors = 0, cmp_count = 0, oe_lat, we_lat, k, b;
    int pg[4], wid[4], wd[4], od[4];
    initial forever #2 clk_in = ~clk_in;
    static_cs_config_timing u_dut (.clk_in, .rst_n_in, .power_on_reset_n_in, .bank_polarity_strap_in,
        .bank1_width_strap_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .ready_out, .req_in,
        .req_ready_out, .cs_out, .we_n_out, .oe_n_out, .mem_addr_out, .cur_width_out, .busy_out);
    static_mem_model u_mem (.clk_in, .cs_in(cs_out), .pol_in(pv), .oe_n_in(oe_n_out), .we_n_in(we_n_out),
        .oe_lat_out(oe_lat), .we_lat_out(we_lat));
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a; wdata_in <= d; wr_in <= 1'h1;
        @(posedge clk_in);
        wr_in <= 1'h0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr_in <= a; rd_in <= 1'h1;
        @(posedge clk_in);
        rd_in <= 1'h0;
        #1;
        chk(rdata_out, e, "rdata");
        chk(ready_out, (a >= 8'h10 && a < 8'h30) ? 1'h0 : 1'h1, "ready");
    endtask : rd
    task check_all;
        for (int i = 0; i < 4; i++) begin
            rd(8'h4 * i, (pv[i] << 6) | (pg[i] << 3) | wid[i]);
            rd(8'h10 + 8'h4 * i, wd[i]);
            rd(8'h20 + 8'h4 * i, od[i]);
        end
    endtask : check_all
    task mreq(input bit w, input int n, input int m);
        int eff;
        eff = (pg[n] && !w) ? ((m > 4) ? 4 : ((m < 1) ? 1 : m)) : 1;
        @(posedge clk_in);
        req_in <= '{1'h1, w, n[1:0], m[2:0], 32'h100 * n};
        #1;
        chk(cs_out, pv ^ 4'hF, "cs idle");
        @(posedge clk_in);
        req_in.valid <= 1'h0;
        #1;
        chk(cur_width_out, wid[n], "width");
        chk(cs_out[n], pv[n], "cs active");
        chk(mem_addr_out, 32'h100 * n, "first address");
        for (int i = 0; i < 100 && busy_out; i++) begin
            @(posedge clk_in);
            #1;
        end
        chk(busy_out, 1'h0, "finished");
        if (w) chk(we_lat, wd[n] + 1, "we delay");
        else chk(oe_lat, od[n], "oe delay");
        chk(mem_addr_out, 32'h100 * n + 4 * (eff - 1), "last address");
    endtask : mreq
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial begin
        #40000;
        n_errors++;
        wrap_up;
    end
    initial begin
        bank_polarity_strap_in = $random(seed);
        bank1_width_strap_in = $unsigned($random(seed)) % 3;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'h1; power_on_reset_n_in <= 1'h1;
        repeat (2) @(posedge clk_in);
        pv = bank_polarity_strap_in;
        wid[1] = bank1_width_strap_in;
        check_all;
        mreq(0, 0, 1);
        mreq(1, 1, 1);
        $display("test reset done");
        for (k = 0; k < 3; k++) begin
            for (b = 0; b < 4; b++) begin
                pv[b] = $random(seed); pg[b] = $random(seed) & 1; wid[b] = $unsigned($random(seed)) % 3;
                wd[b] = $random(seed) & 15; od[b] = $random(seed) & 15;
                wr(8'h4 * b, (pv[b] << 6) | (pg[b] << 3) | wid[b]);
                wr(8'h10 + 8'h4 * b, wd[b]);
                wr(8'h20 + 8'h4 * b, od[b]);
            end
            check_all;
            for (b = 0; b < 4; b++) begin
                mreq(0, b, $random(seed) & 7);
                mreq(1, b, $random(seed) & 7);
            end
            $display("test config %0d done", k);
        end
        rst_n_in <= 1'h0;
        @(posedge clk_in);
        rst_n_in <= 1'h1;
        @(posedge clk_in);
        check_all;
        rd(8'h40, 32'h0);
        $display("test bus reset done");
        wrap_up;
    end
endmodule : tb_static_cs_config_timing
